// ==== rsac_consts.vh ====
`ifndef RSAC_CONSTS_VH
`define RSAC_CONSTS_VH

// Register addresses (word index on the plain register port)
`define RSAC_ADDR_W          3
`define RSAC_A_CTRL          3'h0
`define RSAC_A_SEC_HI        3'h1
`define RSAC_A_SEC_LO        3'h2
`define RSAC_A_SUBSEC        3'h3
`define RSAC_A_ALM_HI        3'h4
`define RSAC_A_ALM_LO        3'h5
`define RSAC_A_INTERVAL      3'h6
`define RSAC_A_TRIM          3'h7

// Control register field positions
`define RSAC_B_RUN           0
`define RSAC_B_TOD_EN        1
`define RSAC_B_IVL_EN        2
`define RSAC_B_BUSY          3
`define RSAC_B_READY         4
`define RSAC_B_RDY_IE        5
`define RSAC_B_TOD_FLAG      6
`define RSAC_B_IVL_FLAG      7
`define RSAC_B_SQE           8
`define RSAC_B_WE            15

// Reset values
`define RSAC_RST_BUSY        1'b1
`define RSAC_RST_READY       1'b0
`define RSAC_RST_SEC         32'h0000_0000
`define RSAC_RST_SUBSEC      8'h00
`define RSAC_RST_ALARM       20'h0_0000
`define RSAC_RST_INTERVAL    8'h00
`define RSAC_RST_TRIM        8'h00

// Timing: 32.768 kHz edges per 256 Hz tick, and the edge that warns of the ripple
`define RSAC_OSC_HZ          32768
`define RSAC_TICK_HZ         256
`define RSAC_PRE_W           7
`define RSAC_PRE_LAST        7'h7F
`define RSAC_PRE_WARN        7'h7E
`define RSAC_SUBSEC_MAX      8'hFF
`define RSAC_ALARM_W         20

`endif

// ==== rsac_prescale.v ====
`timescale 1ns/1ps
`include "rsac_consts.vh"
module rsac_prescale
(
  input  wire mclk,
  input  wire rstn_i,
  input  wire osc_rise,
  output reg  tick_ff,
  output reg  warn_ff
);
  reg  [`RSAC_PRE_W-1:0] div_ff;
  wire [`RSAC_PRE_W-1:0] nxt_div;

  // Free running and untrimmed, so interval alarms never shift
  assign nxt_div = osc_rise ? div_ff + 7'h01 : div_ff;

  always @(posedge mclk or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      div_ff  <= 7'h00;
      tick_ff <= 1'b0;
      warn_ff <= 1'b0;
    end
    else
    begin
      div_ff  <= nxt_div;
      tick_ff <= osc_rise && (div_ff == `RSAC_PRE_LAST);
      warn_ff <= osc_rise && (div_ff == `RSAC_PRE_WARN);
    end
  end
endmodule // rsac_prescale

// ==== rsac_sync.v ====
`timescale 1ns/1ps
module rsac_sync
(
  input  wire       mclk,
  input  wire       rstn_i,
  input  wire [1:0] async_in,
  output wire [1:0] sync_out
);
  reg [1:0] meta_ff;
  reg [1:0] hold_ff;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_bit
      always @(posedge mclk or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          meta_ff[i] <= 1'b0;
          hold_ff[i] <= 1'b0;
        end
        else
        begin
          meta_ff[i] <= async_in[i];
          hold_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign sync_out = hold_ff;
endmodule // rsac_sync

// ==== rsac_tb.sv ====
`timescale 1ns/1ps
module tb;
  reg         mclk;
  reg         rst_n;
  reg         osc_32k;
  reg         sys_irq_en;
  reg  [2:0]  addr;
  reg  [15:0] wr_data;
  reg         wr_stb;
  reg         rd_stb;
  wire [15:0] rd_data_ff;
  wire        irq_ff;
  wire        sq_out_ff;
  integer     err_count;
  integer     total_checks;
  integer     i;
  reg  [15:0] q;
  reg  [15:0] s0;

  rsac_top u_rsac_top
  (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .osc_32k    (osc_32k),
    .sys_irq_en (sys_irq_en),
    .addr       (addr),
    .wr_data    (wr_data),
    .wr_stb     (wr_stb),
    .rd_stb     (rd_stb),
    .rd_data_ff (rd_data_ff),
    .irq_ff     (irq_ff),
    .sq_out_ff  (sq_out_ff)
  );

  always #5 mclk = ~mclk;

  // Oscillator starts late so the reset value of busy can be seen
  initial
  begin
    osc_32k = 1'b0;
    #403;
    forever #40 osc_32k = ~osc_32k;
  end

  task results;
    begin
      $display("checks=%0d mismatches=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task chk(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task wr(input [2:0] a, input [15:0] d);
    begin
      @(posedge mclk);
      addr    <= a;
      wr_data <= d;
      wr_stb  <= 1'b1;
      @(posedge mclk);
      wr_stb  <= 1'b0;
    end
  endtask

  task rd(input [2:0] a, output [15:0] d);
    begin
      @(posedge mclk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 d = rd_data_ff;
    end
  endtask

  // Polls a control bit; running out of tries ends the run
  task wait_bit(input integer b, input v, input integer lim);
    integer n;
    begin
      rd(3'h0, q);
      for (n = 0; n < lim && q[b] !== v; n = n + 1)
        rd(3'h0, q);
      if (q[b] !== v)
      begin
        chk(q[b], v);
        results;
      end
    end
  endtask

  task t_reset;
    begin
      rd(3'h0, q);
      chk(q & 16'h0018, 16'h0008);
      wait_bit(3, 1'b0, 64);
      for (i = 1; i < 4; i = i + 1)
      begin
        rd(i[2:0], q);
        chk(q, 16'h0000);
      end
      wr(3'h6, 16'h01AB);
      rd(3'h6, q);
      chk(q, 16'h00AB);
      $display("t_reset done");
    end
  endtask

  task t_alarm;
    begin
      wr(3'h4, 16'hFFF5);
      wr(3'h5, 16'h0000);
      rd(3'h4, q);
      chk(q, 16'h0005);
      wr(3'h1, 16'hABC4);
      wait_bit(3, 1'b0, 64);
      wr(3'h2, 16'hFFFF);
      wait_bit(3, 1'b0, 64);
      wr(3'h3, 16'h00FE);
      wait_bit(3, 1'b0, 64);
      rd(3'h3, q);
      chk(q, 16'h00FE);
      @(posedge mclk);
      sys_irq_en <= 1'b1;
      wr(3'h0, 16'h8103);
      wait_bit(3, 1'b0, 64);
      chk({15'h0, sq_out_ff}, 16'h0001);
      wait_bit(6, 1'b1, 2000);
      chk({15'h0, irq_ff}, 16'h0001);
      chk({15'h0, sq_out_ff}, 16'h0000);
      rd(3'h1, q);
      chk(q, 16'hABC5);
      rd(3'h2, q);
      chk(q, 16'h0000);
      @(posedge mclk);
      sys_irq_en <= 1'b0;
      repeat (3) @(posedge mclk);
      #1 chk({15'h0, irq_ff}, 16'h0000);
      @(posedge mclk);
      sys_irq_en <= 1'b1;
      wr(3'h0, 16'h8103);
      repeat (3) @(posedge mclk);
      #1 chk({15'h0, irq_ff}, 16'h0000);
      $display("t_alarm done");
    end
  endtask

  task t_run;
    begin
      rd(3'h3, s0);
      // Back-to-back reads for more than one tick must not hold the count
      for (i = 0; i < 700; i = i + 1)
        rd(3'h3, q);
      chk({15'h0, q != s0}, 16'h0001);
      wr(3'h2, 16'h1234);
      rd(3'h2, q);
      chk(q, 16'h0000);
      wr(3'h0, 16'h0003);
      wr(3'h0, 16'h0002);
      wait_bit(3, 1'b0, 64);
      rd(3'h0, q);
      chk(q & 16'h8101, 16'h0001);
      wr(3'h0, 16'h8003);
      wr(3'h0, 16'h8000);
      wait_bit(3, 1'b0, 64);
      rd(3'h0, q);
      chk(q & 16'h0007, 16'h0000);
      wr(3'h2, 16'h1234);
      wait_bit(3, 1'b0, 64);
      rd(3'h2, q);
      chk(q, 16'h1234);
      $display("t_run done");
    end
  endtask

  // Interval of two ticks: a one-tick or three-tick period trips the checks
  task t_ivl;
    begin
      wr(3'h6, 16'h0002);
      wr(3'h0, 16'h8004);
      wait_bit(3, 1'b0, 64);
      wait_bit(7, 1'b1, 1500);
      chk({15'h0, irq_ff}, 16'h0001);
      wr(3'h0, 16'h8004);
      rd(3'h0, q);
      chk(q & 16'h0090, 16'h0000);
      repeat (1500) @(posedge mclk);
      rd(3'h0, q);
      chk(q & 16'h0090, 16'h0010);
      wait_bit(7, 1'b1, 400);
      $display("t_ivl done");
    end
  endtask

  initial
  begin
    mclk         = 1'b0;
    rst_n        = 1'b0;
    sys_irq_en   = 1'b0;
    addr         = 3'h0;
    wr_data      = 16'h0000;
    wr_stb       = 1'b0;
    rd_stb       = 1'b0;
    err_count    = 0;
    total_checks = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset;
    t_alarm;
    t_run;
    t_ivl;
    results;
  end
endmodule // tb

// ==== rsac_top.v ====
`timescale 1ns/1ps
`include "rsac_consts.vh"
// Notes on behaviour
// - Sub-second counter advances per 256Hz tick
// - Sub-second rollover increments seconds counter
// - Separate auto-reload interval alarm counter
// - Count writes only while stopped; reads never pause
// - One 16-bit control register holds controls
// - Seconds loaded only by high/low writes
// - Sub-second register loads and reads counter
// - Alarm matches low 20 seconds bits only
// - Interval alarm uses untrimmed 256Hz tick
// - Alarm low 16 bits, high nibble separately
// - Match at rollover sets alarm flag once
// - Interrupt needs flag, enable, system enable
// - Busy blocks run/enable and count writes until 32k edge
// - Ready drops before ripple, rises after
// - Interval reloads at each interval hit; zero means maximum
module rsac_top
(
  input  wire                    mclk,
  input  wire                    rst_n,
  input  wire                    osc_32k,
  input  wire                    sys_irq_en,
  input  wire [`RSAC_ADDR_W-1:0] addr,
  input  wire [15:0]             wr_data,
  input  wire                    wr_stb,
  input  wire                    rd_stb,
  output reg  [15:0]             rd_data_ff,
  output reg                     irq_ff,
  output reg                     sq_out_ff
);
  reg         rst_s1_ff;
  reg         rst_s2_ff;
  wire        rstn_i;
  wire [1:0]  osc_sync;
  reg         osc_prev_ff;
  wire        osc_rise;
  wire        tick;
  wire        warn;

  reg         we_ff;
  reg         run_ff;
  reg         tod_en_ff;
  reg         ivl_en_ff;
  reg         p_run_ff;
  reg         p_tod_en_ff;
  reg         p_ivl_en_ff;
  reg         busy_ff;
  reg         ready_ff;
  reg         rdy_ie_ff;
  reg         tod_flag_ff;
  reg         ivl_flag_ff;
  reg         sqe_ff;
  reg  [31:0] sec_ff;
  reg  [7:0]  subsec_ff;
  reg  [15:0] ld_hi_ff;
  reg  [15:0] ld_lo_ff;
  reg  [7:0]  ld_sub_ff;
  reg         ld_hi_pend_ff;
  reg         ld_lo_pend_ff;
  reg         ld_sub_pend_ff;
  reg  [`RSAC_ALARM_W-1:0] alarm_ff;
  reg  [7:0]  interval_ff;
  reg  [7:0]  ivl_reload_ff;
  reg  [7:0]  ivl_cnt_ff;
  reg  [7:0]  trim_ff;

  wire        wr_ctrl;
  wire        wr_count;
  wire        ctl_change;
  wire        run_req;
  wire        run_ok;
  wire        set_busy;
  wire [31:0] nxt_sec;
  wire        rollover;
  wire        tod_match;
  wire        ivl_hit;
  wire [7:0]  nxt_ivl_cnt;
  wire        tod_clr;
  wire        ivl_clr;
  wire        rdy_clr;
  reg  [15:0] nxt_rd_data;

  // Reset is released through two flops; assertion stays asynchronous
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rstn_i = rst_s2_ff;

  rsac_sync u_sync
  (
    .mclk     (mclk),
    .rstn_i   (rstn_i),
    .async_in ({1'b0, osc_32k}),
    .sync_out (osc_sync)
  );

  always @(posedge mclk or negedge rstn_i)
  begin
    if (!rstn_i)
      osc_prev_ff <= 1'b0;
    else
      osc_prev_ff <= osc_sync[0];
  end
  assign osc_rise = osc_sync[0] && !osc_prev_ff;

  rsac_prescale u_pre
  (
    .mclk     (mclk),
    .rstn_i   (rstn_i),
    .osc_rise (osc_rise),
    .tick_ff  (tick),
    .warn_ff  (warn)
  );

  // Busy blocks the guarded bits and the count registers
  assign wr_ctrl    = wr_stb && (addr == `RSAC_A_CTRL);
  assign run_req    = wr_data[`RSAC_B_RUN];
  // Stopping the clock needs write enable; starting it does not
  assign run_ok     = run_req || we_ff;
  assign ctl_change = wr_ctrl && !busy_ff &&
                      (((run_req != p_run_ff) && run_ok) ||
                       (wr_data[`RSAC_B_TOD_EN] != p_tod_en_ff) ||
                       (wr_data[`RSAC_B_IVL_EN] != p_ivl_en_ff));
  assign wr_count   = wr_stb && !busy_ff && !run_ff && !p_run_ff &&
                      ((addr == `RSAC_A_SEC_HI) || (addr == `RSAC_A_SEC_LO) ||
                       (addr == `RSAC_A_SUBSEC));
  assign set_busy   = ctl_change || wr_count;

  always @(posedge mclk or negedge rstn_i)
  begin
    if (!rstn_i)
      busy_ff <= `RSAC_RST_BUSY;
    else if (set_busy)
      busy_ff <= 1'b1;
    else if (osc_rise)
      busy_ff <= 1'b0;
  end

  // Pending copies in the fast domain; applied copies change only on a 32k edge
  always @(posedge mclk or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      p_run_ff       <= 1'b0;
      p_tod_en_ff    <= 1'b0;
      p_ivl_en_ff    <= 1'b0;
      run_ff         <= 1'b0;
      tod_en_ff      <= 1'b0;
      ivl_en_ff      <= 1'b0;
      we_ff          <= 1'b0;
      rdy_ie_ff      <= 1'b0;
      sqe_ff         <= 1'b0;
      ld_hi_ff       <= 16'h0000;
      ld_lo_ff       <= 16'h0000;
      ld_sub_ff      <= 8'h00;
      ld_hi_pend_ff  <= 1'b0;
      ld_lo_pend_ff  <= 1'b0;
      ld_sub_pend_ff <= 1'b0;
    end
    else
    begin
      // Clear first, so a load written on a 32k edge waits for the next edge
      if (osc_rise)
      begin
        run_ff         <= p_run_ff;
        tod_en_ff      <= p_tod_en_ff;
        ivl_en_ff      <= p_ivl_en_ff;
        ld_hi_pend_ff  <= 1'b0;
        ld_lo_pend_ff  <= 1'b0;
        ld_sub_pend_ff <= 1'b0;
      end
      if (wr_ctrl)
      begin
        we_ff     <= wr_data[`RSAC_B_WE];
        rdy_ie_ff <= wr_data[`RSAC_B_RDY_IE];
        sqe_ff    <= wr_data[`RSAC_B_SQE];
      end
      if (ctl_change)
      begin
        if (run_ok)
          p_run_ff <= run_req;
        p_tod_en_ff <= wr_data[`RSAC_B_TOD_EN];
        p_ivl_en_ff <= wr_data[`RSAC_B_IVL_EN];
      end
      if (wr_count && (addr == `RSAC_A_SEC_HI))
      begin
        ld_hi_ff      <= wr_data;
        ld_hi_pend_ff <= 1'b1;
      end
      if (wr_count && (addr == `RSAC_A_SEC_LO))
      begin
        ld_lo_ff      <= wr_data;
        ld_lo_pend_ff <= 1'b1;
      end
      if (wr_count && (addr == `RSAC_A_SUBSEC))
      begin
        ld_sub_ff      <= wr_data[7:0];
        ld_sub_pend_ff <= 1'b1;
      end
    end
  end

  // Time keeping chain
  assign rollover  = tick && run_ff && (subsec_ff == `RSAC_SUBSEC_MAX);
  assign nxt_sec   = sec_ff + 32'h0000_0001;
  assign tod_match = (nxt_sec[`RSAC_ALARM_W-1:0] == alarm_ff);

  always @(posedge mclk or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sec_ff    <= `RSAC_RST_SEC;
      subsec_ff <= `RSAC_RST_SUBSEC;
    end
    else if (osc_rise)
    begin
      // Only the seconds registers can load the stored seconds
      if (ld_hi_pend_ff)
        sec_ff[31:16] <= ld_hi_ff;
      if (ld_lo_pend_ff)
        sec_ff[15:0] <= ld_lo_ff;
      if (ld_sub_pend_ff)
        subsec_ff <= ld_sub_ff;
    end
    else if (tick && run_ff)
    begin
      subsec_ff <= subsec_ff + 8'h01;
      if (rollover)
        sec_ff <= nxt_sec;
    end
  end

  // Interval alarm: own counter, reload latched on each interval hit and while disabled
  assign nxt_ivl_cnt = ivl_cnt_ff + 8'h01;
  assign ivl_hit     = tick && ivl_en_ff && (nxt_ivl_cnt == ivl_reload_ff);

  always @(posedge mclk or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ivl_cnt_ff    <= 8'h00;
      ivl_reload_ff <= `RSAC_RST_INTERVAL;
    end
    else if (!ivl_en_ff)
    begin
      ivl_cnt_ff    <= 8'h00;
      ivl_reload_ff <= interval_ff;
    end
    else if (tick)
    begin
      // A reload of zero matches only after the full 256-tick wrap
      if (ivl_hit)
      begin
        ivl_cnt_ff    <= 8'h00;
        ivl_reload_ff <= interval_ff;
      end
      else
        ivl_cnt_ff <= nxt_ivl_cnt;
    end
  end

  // Flags: a hardware set in the same cycle beats a software clear
  assign tod_clr = wr_ctrl && !wr_data[`RSAC_B_TOD_FLAG];
  assign ivl_clr = wr_ctrl && !wr_data[`RSAC_B_IVL_FLAG];
  assign rdy_clr = wr_ctrl && !wr_data[`RSAC_B_READY];

  always @(posedge mclk or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tod_flag_ff <= 1'b0;
      ivl_flag_ff <= 1'b0;
      ready_ff    <= `RSAC_RST_READY;
    end
    else
    begin
      if (rollover && tod_en_ff && tod_match)
        tod_flag_ff <= 1'b1;
      else if (tod_clr)
        tod_flag_ff <= 1'b0;
      if (ivl_hit)
        ivl_flag_ff <= 1'b1;
      else if (ivl_clr)
        ivl_flag_ff <= 1'b0;
      if (tick)
        ready_ff <= 1'b1;
      else if (warn || rdy_clr)
        ready_ff <= 1'b0;
    end
  end

  // Alarm registers only take writes while their alarm is off
  always @(posedge mclk or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      alarm_ff    <= `RSAC_RST_ALARM;
      interval_ff <= `RSAC_RST_INTERVAL;
      trim_ff     <= `RSAC_RST_TRIM;
    end
    else if (wr_stb)
    begin
      if ((addr == `RSAC_A_ALM_HI) && !tod_en_ff && !p_tod_en_ff)
        alarm_ff[19:16] <= wr_data[3:0];
      if ((addr == `RSAC_A_ALM_LO) && !tod_en_ff && !p_tod_en_ff)
        alarm_ff[15:0] <= wr_data;
      if ((addr == `RSAC_A_INTERVAL) && !ivl_en_ff && !p_ivl_en_ff)
        interval_ff <= wr_data[7:0];
      if ((addr == `RSAC_A_TRIM) && we_ff && !busy_ff)
        trim_ff <= wr_data[7:0];
    end
  end

  // Reads are side-effect free, so counting never stalls for them
  always @*
  begin
    nxt_rd_data = 16'h0000;
    case (addr)
      `RSAC_A_CTRL:
      begin
        nxt_rd_data[`RSAC_B_RUN]      = run_ff;
        nxt_rd_data[`RSAC_B_TOD_EN]   = tod_en_ff;
        nxt_rd_data[`RSAC_B_IVL_EN]   = ivl_en_ff;
        nxt_rd_data[`RSAC_B_BUSY]     = busy_ff;
        nxt_rd_data[`RSAC_B_READY]    = ready_ff;
        nxt_rd_data[`RSAC_B_RDY_IE]   = rdy_ie_ff;
        nxt_rd_data[`RSAC_B_TOD_FLAG] = tod_flag_ff;
        nxt_rd_data[`RSAC_B_IVL_FLAG] = ivl_flag_ff;
        nxt_rd_data[`RSAC_B_SQE]      = sqe_ff;
        nxt_rd_data[`RSAC_B_WE]       = we_ff;
      end
      `RSAC_A_SEC_HI:   nxt_rd_data = sec_ff[31:16];
      `RSAC_A_SEC_LO:   nxt_rd_data = sec_ff[15:0];
      `RSAC_A_SUBSEC:   nxt_rd_data = {8'h00, subsec_ff};
      `RSAC_A_ALM_HI:   nxt_rd_data = {12'h000, alarm_ff[19:16]};
      `RSAC_A_ALM_LO:   nxt_rd_data = alarm_ff[15:0];
      `RSAC_A_INTERVAL: nxt_rd_data = {8'h00, interval_ff};
      `RSAC_A_TRIM:     nxt_rd_data = {8'h00, trim_ff};
      default:          nxt_rd_data = 16'h0000;
    endcase
  end

  always @(posedge mclk or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rd_data_ff <= 16'h0000;
      irq_ff     <= 1'b0;
      sq_out_ff  <= 1'b0;
    end
    else
    begin
      rd_data_ff <= rd_stb ? nxt_rd_data : 16'h0000;
      irq_ff     <= sys_irq_en && ((tod_flag_ff && tod_en_ff) ||
                                   (ivl_flag_ff && ivl_en_ff) ||
                                   (ready_ff && rdy_ie_ff));
      // 1 Hz square wave taken from the top sub-second bit
      sq_out_ff  <= sqe_ff && subsec_ff[7];
    end
  end
endmodule // rsac_top

// ==== rsac_top_props.sv ====
`timescale 1ns/1ps
module rsac_top_props
(
  input wire        mclk,
  input wire        rst_n,
  input wire        osc_32k,
  input wire        sys_irq_en,
  input wire [2:0]  addr,
  input wire [15:0] wr_data,
  input wire        wr_stb,
  input wire        rd_stb,
  input wire [15:0] rd_data_ff,
  input wire        irq_ff,
  input wire        sq_out_ff
);
  reg       sqe_ff;
  reg [2:0] sqe_hist_ff;

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // SQE is never refused, so the last written value is what the output obeys
  always @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      sqe_ff      <= 1'b0;
      sqe_hist_ff <= 3'h0;
    end
    else
    begin
      if (wr_stb && addr == 3'h0)
        sqe_ff <= wr_data[8];
      sqe_hist_ff <= {sqe_hist_ff[1:0], sqe_ff};
    end

  rd_idle_a: assert property (!rd_stb |=> rd_data_ff == 16'h0000)
    else $error("read data not zero outside a read");
  ctrl_res_a: assert property (rd_stb && addr == 3'h0 |=> rd_data_ff[14:9] == 6'h00)
    else $error("unused control bits read nonzero");
  narrow_regs_a: assert property (rd_stb && (addr == 3'h3 || addr == 3'h6) |=> rd_data_ff[15:8] == 8'h00)
    else $error("eight bit register reads wide");
  alm_hi_a: assert property (rd_stb && addr == 3'h4 |=> rd_data_ff[15:4] == 12'h000)
    else $error("alarm high reads beyond four bits");
  irq_gate_a: assert property (!sys_irq_en |=> !irq_ff)
    else $error("interrupt without system enable");
  irq_rise_a: assert property ($rose(irq_ff) |-> $past(sys_irq_en))
    else $error("interrupt rose while disabled");
  sq_off_a: assert property (!sqe_ff && sqe_hist_ff == 3'h0 |-> !sq_out_ff)
    else $error("square wave active while disabled");
  sq_hold_a: assert property ($changed(sq_out_ff) |=> $stable(sq_out_ff) [*8])
    else $error("square wave toggles too fast");

  cover property ($rose(irq_ff));
  cover property ($fell(sq_out_ff));
  cover property (rd_stb && addr == 3'h4);
endmodule // rsac_top_props

bind rsac_top rsac_top_props u_rsac_top_props
(
  .mclk       (mclk),
  .rst_n      (rst_n),
  .osc_32k    (osc_32k),
  .sys_irq_en (sys_irq_en),
  .addr       (addr),
  .wr_data    (wr_data),
  .wr_stb     (wr_stb),
  .rd_stb     (rd_stb),
  .rd_data_ff (rd_data_ff),
  .irq_ff     (irq_ff),
  .sq_out_ff  (sq_out_ff)
);
